// ### cpt_regs.sv
// Card power, timeout and combined status register bank
`timescale 1ns/1ns
`default_nettype none
module cpt_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host parallel bus
  input wire logic [cpt_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_cs_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [7:0] bus_data_in,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe,
  // UART context
  input wire logic [1:0] card_select,
  input wire logic uart_soft_reset_n,
  input wire logic sync_mode,
  input wire logic protocol_t1,
  input wire logic dir_transmit,
  input wire logic last_character_flag,
  input wire logic char_transmitted,
  input wire logic rx_fifo_full,
  input wire logic fifo_empty_flag,
  input wire logic clock_source_switched,
  input wire logic etu_tick,
  input wire logic prescaler_tick,
  input wire logic start_bit_seen,
  input wire logic card_clock_active,
  // Card sense
  input wire logic [1:0] contact_four_line,
  input wire logic [1:0] contact_eight_line,
  input wire logic card_a_present,
  input wire logic card_b_present,
  input wire logic aux_interrupt_input,
  input wire logic [1:0] card_activated,
  input wire logic [1:0] emergency_deact,
  // Card control
  output logic [1:0] contact_four_pullup,
  output logic [1:0] contact_eight_pullup,
  output logic [1:0][1:0] card_supply_sel,
  output logic [1:0] card_reset_pin,
  output logic [1:0] card_start,
  output logic [1:0] activate_req,
  output logic [1:0] deactivate_req,
  // Status
  output logic tx_empty_rx_full_flag,
  output logic control_ready,
  output logic block_guard_flag,
  output logic [2:0] timeout_event
);
  import cpt_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic strobe_end(input logic was, input logic now);
    return was & ~now;
  endfunction

  function automatic logic [1:0] vcc_code(input logic [3:0] low);
    if (low[PWR_LV])
      return VCC_1V8;
    else if (low[PWR_LEVEL])
      return VCC_3V;
    else
      return VCC_5V;
  endfunction

  // ==========================================================================
  // Bus strobes
  logic rd_act;
  logic wr_act;
  logic rd_q;
  logic wr_q;
  logic [3:0] addr_q;
  logic [7:0] data_q;
  logic rd_done;
  logic wr_done;
  logic wr_pwr;
  logic wr_cfg;
  logic cfg_load;
  logic hold_evt;

  assign rd_act = ~bus_cs_n & ~bus_rd_n;
  assign wr_act = ~bus_cs_n & ~bus_wr_n;
  // Strobe end is the trailing edge, either RD/WR or CS rising
  assign rd_done = strobe_end(rd_q, rd_act);
  assign wr_done = strobe_end(wr_q, wr_act);
  assign wr_pwr = wr_done && addr_q == PWR_OFS;
  assign wr_cfg = wr_done && addr_q == CFG_OFS;
  assign cfg_load = wr_cfg & uart_soft_reset_n;
  assign hold_evt = (rd_done | wr_done) && addr_q == HOLDING_OFS;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 4'h0;
      data_q <= 8'h00;
    end
    else
    begin
      rd_q <= rd_act;
      wr_q <= wr_act;
      if (rd_act | wr_act)
      begin
        addr_q <= bus_addr;
        data_q <= bus_data_in;
      end
    end
  end

  // ==========================================================================
  // Per-card power control copies
  logic [1:0][3:0] pwr_low_reg;
  logic [1:0] ct4_reg;
  logic [1:0] ct8_reg;
  logic card_sel;
  logic [1:0] card_hit;

  assign card_sel = card_select != CARD_AUX;
  // Auxiliary selection hits no copy
  assign card_hit = {wr_pwr & card_sel & card_select[0],
                     wr_pwr & card_sel & ~card_select[0]};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_low_reg <= {2{PWR_LOW_RESET}};
      ct4_reg <= 2'h3;
      ct8_reg <= 2'h3;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!uart_soft_reset_n)
        begin
          ct4_reg[i] <= 1'b1;
          ct8_reg[i] <= 1'b1;
        end
        else if (card_hit[i])
        begin
          ct4_reg[i] <= data_q[PWR_CT4];
          ct8_reg[i] <= data_q[PWR_CT8];
        end
        if (card_hit[i])
          pwr_low_reg[i][3:1] <= data_q[3:1];
        // Emergency beats a same-cycle software start, for safety
        if (emergency_deact[i])
          pwr_low_reg[i][PWR_START] <= 1'b0;
        else if (card_hit[i])
          pwr_low_reg[i][PWR_START] <= data_q[PWR_START];
      end
    end
  end

  // ==========================================================================
  // Card-side outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      contact_four_pullup <= 2'h3;
      contact_eight_pullup <= 2'h3;
      card_supply_sel <= {2{VCC_5V}};
      card_reset_pin <= 2'h0;
      card_start <= 2'h0;
      activate_req <= 2'h0;
      deactivate_req <= 2'h0;
    end
    else
    begin
      contact_four_pullup <= ct4_reg;
      contact_eight_pullup <= ct8_reg;
      for (int i = 0; i < 2; i++)
      begin
        card_supply_sel[i] <= vcc_code(pwr_low_reg[i]);
        card_reset_pin[i] <= card_activated[i] & pwr_low_reg[i][PWR_RST];
        card_start[i] <= pwr_low_reg[i][PWR_START];
        activate_req[i] <= card_hit[i] & data_q[PWR_START];
        deactivate_req[i] <= card_hit[i] & ~data_q[PWR_START];
      end
    end
  end

  // ==========================================================================
  // Timeout configuration and reloads
  logic [7:0] cfg_reg;
  logic [7:0] tor_low_reg;
  logic [7:0] tor_mid_reg;
  logic [7:0] tor_high_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_reg <= CFG_RESET;
    else if (!uart_soft_reset_n)
      cfg_reg <= CFG_RESET;
    else if (wr_cfg)
      cfg_reg <= data_q;
  end

  // Only power-on reset touches the reloads
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tor_low_reg <= 8'h00;
      tor_mid_reg <= 8'h00;
      tor_high_reg <= 8'h00;
    end
    else
    begin
      if (wr_done && addr_q == TOR_LOW_OFS)
        tor_low_reg <= data_q;
      if (wr_done && addr_q == TOR_MID_OFS)
        tor_mid_reg <= data_q;
      if (wr_done && addr_q == TOR_HIGH_OFS)
        tor_high_reg <= data_q;
    end
  end

  // ==========================================================================
  // Timeout counters
  logic [23:0] cnt_reg;
  logic run;

  assign run = etu_tick & card_clock_active;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 24'h000000;
      timeout_event <= 3'h0;
    end
    else
    begin
      timeout_event <= 3'h0;
      if (cfg_load)
        cnt_reg <= {tor_high_reg, tor_mid_reg, tor_low_reg};
      else if (run && cfg_reg[CFG_JOIN])
      begin
        // One 24-bit count
        if (cfg_reg[CFG_EN_HIGH] && cnt_reg != 24'h000000)
        begin
          cnt_reg <= cnt_reg - 24'h000001;
          timeout_event[2] <= cnt_reg == 24'h000001;
        end
      end
      else if (run)
      begin
        if (cfg_reg[CFG_EN_LOW] && cnt_reg[7:0] != 8'h00)
        begin
          cnt_reg[7:0] <= cnt_reg[7:0] - 8'h01;
          timeout_event[0] <= cnt_reg[7:0] == 8'h01;
        end
        if (cfg_reg[CFG_EN_HIGH] && cnt_reg[23:8] != 16'h0000)
        begin
          cnt_reg[23:8] <= cnt_reg[23:8] - 16'h0001;
          timeout_event[1] <= cnt_reg[23:8] == 16'h0001;
        end
      end
    end
  end

  // ==========================================================================
  // Block guard time
  logic [4:0] guard_cnt;
  logic [4:0] guard_term;

  assign guard_term = protocol_t1 ? GUARD_TERM_T1 : GUARD_TERM_T0;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      guard_cnt <= 5'h00;
      block_guard_flag <= 1'b0;
    end
    else if (start_bit_seen)
    begin
      guard_cnt <= 5'h00;
      block_guard_flag <= 1'b0;
    end
    else if (guard_cnt >= guard_term)
      block_guard_flag <= 1'b1;
    else if (etu_tick)
      guard_cnt <= guard_cnt + 5'h01;
  end

  // ==========================================================================
  // Transmit empty / receive full flag
  logic dir_q;
  logic full_q;
  logic flag_set;
  logic flag_clr;

  // Last character with its flag set leaves the bit alone
  assign flag_set = (dir_transmit & ~dir_q) | (char_transmitted & ~last_character_flag)
                 | (rx_fifo_full & ~full_q);
  assign flag_clr = (wr_done && addr_q == HOLDING_OFS && dir_transmit)
                 | (rd_done && addr_q == HOLDING_OFS && !dir_transmit)
                 | (~dir_transmit & dir_q);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dir_q <= 1'b0;
      full_q <= 1'b0;
      tx_empty_rx_full_flag <= 1'b0;
    end
    else
    begin
      dir_q <= dir_transmit;
      full_q <= rx_fifo_full;
      if (!uart_soft_reset_n)
        tx_empty_rx_full_flag <= 1'b0;
      else if (flag_set)
        tx_empty_rx_full_flag <= 1'b1;
      else if (flag_clr)
        tx_empty_rx_full_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Control ready
  logic [1:0] hold_cnt;
  logic [1:0] hold_next;
  cpt_cfg_wait_t tw_state;
  cpt_cfg_wait_t tw_next;

  always_comb
  begin
    hold_next = hold_cnt;
    if (hold_evt)
      hold_next = READY_HOLD_CYCLES;
    else if (hold_cnt != 2'h0)
      hold_next = hold_cnt - 2'h1;
  end

  // Leaving on the second fraction tick bounds the wait to one..two fractions
  always_comb
  begin
    tw_next = tw_state;
    if (cfg_load)
      tw_next = TW_FIRST;
    else
    begin
      case (tw_state)
        TW_IDLE: tw_next = TW_IDLE;
        TW_FIRST: tw_next = prescaler_tick ? TW_SECOND : TW_FIRST;
        TW_SECOND: tw_next = prescaler_tick ? TW_IDLE : TW_SECOND;
        default: tw_next = TW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_cnt <= 2'h0;
      tw_state <= TW_IDLE;
      control_ready <= 1'b1;
    end
    else
    begin
      hold_cnt <= hold_next;
      tw_state <= tw_next;
      control_ready <= sync_mode | ~uart_soft_reset_n
                     | (hold_next == 2'h0 && tw_next == TW_IDLE);
    end
  end

  // ==========================================================================
  // Read path
  logic [7:0] pwr_read;
  logic [7:0] stat_read;
  logic mapped;

  assign pwr_read = card_sel ? {2'b00, contact_eight_line[card_select[0]],
                    contact_four_line[card_select[0]],
                    pwr_low_reg[card_select[0]]} : 8'h00;
  assign stat_read = {clock_source_switched,
                     fifo_empty_flag | ~uart_soft_reset_n,
                     block_guard_flag, control_ready,
                     card_b_present, card_a_present,
                     aux_interrupt_input,
                     tx_empty_rx_full_flag};
  assign mapped = bus_addr >= PWR_OFS && bus_addr <= STAT_OFS;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_data_out <= 8'h00;
      bus_data_oe <= 1'b0;
    end
    else
    begin
      bus_data_oe <= rd_act & mapped;
      case (bus_addr)
        PWR_OFS: bus_data_out <= pwr_read;
        CFG_OFS: bus_data_out <= cfg_reg;
        STAT_OFS: bus_data_out <= stat_read;
        default: bus_data_out <= 8'h00; // Write-only and unmapped read zero
      endcase
    end
  end

  // ==========================================================================
  // Checks
  soft_contact_a: assert property (@(posedge clk) disable iff (!rst_n)
    !uart_soft_reset_n |=> ct4_reg == 2'h3 && ct8_reg == 2'h3)
    else $error("contact bits not set by soft reset");

  supply_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
    pwr_low_reg[0][PWR_LV] && $stable(pwr_low_reg[0]) |=> card_supply_sel[0] == VCC_1V8)
    else $error("low voltage not selected");

  reset_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 card_reset_pin[1] == $past(card_activated[1] & pwr_low_reg[1][PWR_RST]))
    else $error("card reset pin mismatch");

  emerg_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    emergency_deact[0] |=> !pwr_low_reg[0][PWR_START] ##1 !card_start[0])
    else $error("start not cleared by emergency");

  cfg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !uart_soft_reset_n |=> cfg_reg == CFG_RESET)
    else $error("configuration not held at zero");

  count_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !card_clock_active && !cfg_load |=> $stable(cnt_reg) && timeout_event == 3'h0)
    else $error("timeout counted without card clock");

  guard_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    start_bit_seen |=> !block_guard_flag && guard_cnt == 5'h00)
    else $error("guard counter not restarted");

  ready_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    hold_evt && !sync_mode && uart_soft_reset_n && $stable(sync_mode)
    && $stable(uart_soft_reset_n) |=> !control_ready)
    else $error("ready not dropped after holding access");

  ready_back_a: assert property (@(posedge clk) disable iff (!rst_n)
    hold_evt |-> ##[1:3] hold_cnt != 2'h0 ##[1:3] hold_cnt == 2'h0 || hold_evt)
    else $error("ready hold length wrong");

  flag_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    dir_transmit && !dir_q && uart_soft_reset_n |=> tx_empty_rx_full_flag)
    else $error("flag not set on direction change");

endmodule
`default_nettype wire

// ### cpt_pkg.sv
// Constants and types for the card power, timeout and status register bank
package cpt_pkg;
  // ==========================================================================
  // Bus and offsets
  localparam int ADDR_W = 4;
  localparam logic [3:0] PWR_OFS = 4'h7;
  localparam logic [3:0] CFG_OFS = 4'h8;
  localparam logic [3:0] TOR_LOW_OFS = 4'h9;
  localparam logic [3:0] TOR_MID_OFS = 4'ha;
  localparam logic [3:0] TOR_HIGH_OFS = 4'hb;
  localparam logic [3:0] STAT_OFS = 4'hc;
  localparam logic [3:0] HOLDING_OFS = 4'hd;
  // ==========================================================================
  // Power control fields
  localparam int PWR_CT8 = 5;
  localparam int PWR_CT4 = 4;
  localparam int PWR_LV = 3;
  localparam int PWR_RST = 2;
  localparam int PWR_LEVEL = 1;
  localparam int PWR_START = 0;
  localparam logic [3:0] PWR_LOW_RESET = 4'h0;
  localparam logic [1:0] CARD_AUX = 2'h2;
  localparam logic [1:0] VCC_5V = 2'h0;
  localparam logic [1:0] VCC_3V = 2'h1;
  localparam logic [1:0] VCC_1V8 = 2'h2;
  // ==========================================================================
  // Timeout configuration fields
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_EN_LOW = 0;
  localparam int CFG_EN_HIGH = 1;
  localparam int CFG_JOIN = 2;
  // ==========================================================================
  // Timing
  localparam logic [1:0] READY_HOLD_CYCLES = 2'h3;
  localparam logic [4:0] GUARD_TERM_T0 = 5'h10;
  localparam logic [4:0] GUARD_TERM_T1 = 5'h16;
  typedef enum logic [1:0] {
    TW_IDLE = 2'b00,
    TW_FIRST = 2'b01,
    TW_SECOND = 2'b10
  } cpt_cfg_wait_t;
endpackage

// ### cpt_host.sv
// Host bus model: register reads and writes on the parallel bus
`timescale 1ns/1ns
`default_nettype none
module cpt_host
(
  // Clock
  input wire logic clk,
  // Parallel bus
  output logic [cpt_pkg::ADDR_W-1:0] addr,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] dout,
  input wire logic [7:0] din,
  input wire logic oe,
  input wire logic ready
);
  import cpt_pkg::*;
  // ====================
  // Bus cycles
  initial
  begin
    addr = 4'h0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    dout = 8'h00;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Device refuses nothing while busy, so poll first
  task automatic wait_ready();
    for (int n = 0; n < 100 && ready !== 1'b1; n++)
      tick();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    if (a == CFG_OFS || a == HOLDING_OFS)
      wait_ready();
    addr = a;
    dout = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    tick();
    cs_n = 1'b1;
    wr_n = 1'b1;
    // Released lines never keep the old value
    addr = ~a;
    dout = ~d;
    repeat (3) tick();
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic e);
    if (a == HOLDING_OFS)
      wait_ready();
    addr = a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    tick();
    d = din;
    e = oe;
    cs_n = 1'b1;
    rd_n = 1'b1;
    addr = ~a;
    tick();
  endtask
endmodule
`default_nettype wire

// ### cpt_regs_tb.sv
// Self-checking bench for the card power, timeout and status registers
`timescale 1ns/1ns
`default_nettype none
module cpt_regs_tb;
  import cpt_pkg::*;
  logic clk, rst_n, bus_cs_n, bus_rd_n, bus_wr_n, bus_data_oe, e;
  logic [3:0] bus_addr;
  logic [7:0] bus_data_in, bus_data_out, d;
  logic [1:0] card_select, contact_four_line, contact_eight_line, card_activated;
  logic [1:0] emergency_deact, contact_four_pullup, contact_eight_pullup;
  logic [1:0] card_reset_pin, card_start, activate_req, deactivate_req;
  logic [1:0][1:0] card_supply_sel;
  logic [2:0] timeout_event;
  logic uart_soft_reset_n, sync_mode, protocol_t1, dir_transmit, last_character_flag;
  logic char_transmitted, rx_fifo_full, fifo_empty_flag, clock_source_switched;
  logic etu_tick, prescaler_tick, start_bit_seen, card_clock_active, card_a_present;
  logic card_b_present, aux_interrupt_input, tx_empty_rx_full_flag, control_ready;
  logic block_guard_flag;
  int fails, compares, cyc, rlow, act_n, deact_n;
  int ev[3];
  logic [7:0] pwr_w[4] = '{8'h18, 8'h2a, 8'h32, 8'h00};
  logic [1:0] sup_x[4] = '{VCC_1V8, VCC_1V8, VCC_3V, VCC_5V};
  cpt_regs cpt_regs_i
  (
    .clk, .rst_n, .bus_addr, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_data_in,
    .bus_data_out, .bus_data_oe, .card_select, .uart_soft_reset_n, .sync_mode,
    .protocol_t1, .dir_transmit, .last_character_flag, .char_transmitted,
    .rx_fifo_full, .fifo_empty_flag, .clock_source_switched, .etu_tick,
    .prescaler_tick, .start_bit_seen, .card_clock_active, .contact_four_line,
    .contact_eight_line, .card_a_present, .card_b_present, .aux_interrupt_input,
    .card_activated, .emergency_deact, .contact_four_pullup, .contact_eight_pullup,
    .card_supply_sel, .card_reset_pin, .card_start, .activate_req, .deactivate_req,
    .tx_empty_rx_full_flag, .control_ready, .block_guard_flag, .timeout_event
  );
  cpt_host cpt_host_i
  (
    .clk, .addr(bus_addr), .cs_n(bus_cs_n), .rd_n(bus_rd_n), .wr_n(bus_wr_n),
    .dout(bus_data_in), .din(bus_data_out), .oe(bus_data_oe), .ready(control_ready)
  );
  // ====================
  // Clock, tick sources and monitors
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    etu_tick <= #1 (cyc % 8 == 7);
    prescaler_tick <= #1 cyc[0];
    if (control_ready === 1'b0)
      rlow <= rlow + 1;
    if (activate_req[0] === 1'b1)
      act_n <= act_n + 1;
    if (deactivate_req[0] === 1'b1)
      deact_n <= deact_n + 1;
    for (int i = 0; i < 3; i++)
      if (timeout_event[i] === 1'b1)
        ev[i] <= ev[i] + 1;
    // Cut a hang short well beyond the expected run
    if (cyc == 20000)
    begin
      fails = fails + 1;
      stop_test();
    end
  end
  // ====================
  // Tasks
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic ticks(input int n);
    repeat (n) tick();
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] x);
    compares++;
    if (g !== x)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chk1(input logic g, input logic x);
    chk8(8'(g), 8'(x));
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    cpt_host_i.wr(a, x);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
    cpt_host_i.rd(a, d, e);
    chk8(d & m, x);
    chk1(e, 1'b1);
  endtask
  task automatic send_char(input logic last);
    last_character_flag = last;
    char_transmitted = 1'b1;
    tick();
    char_transmitted = 1'b0;
    ticks(2);
  endtask
  task automatic stop_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ====================
  // Main sequence
  initial
  begin
    {rst_n, sync_mode, protocol_t1, dir_transmit, last_character_flag} = '0;
    {char_transmitted, rx_fifo_full, etu_tick, prescaler_tick, start_bit_seen} = '0;
    {card_clock_active, card_activated, emergency_deact, card_select} = '0;
    {fails, compares, cyc, rlow, act_n, deact_n} = '0;
    ev = '{0, 0, 0};
    uart_soft_reset_n = 1'b1;
    contact_four_line = 2'b01;
    contact_eight_line = 2'b10;
    {clock_source_switched, fifo_empty_flag, card_a_present, card_b_present} = 4'b1010;
    aux_interrupt_input = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick();
    chk8(8'({contact_eight_pullup, contact_four_pullup}), 8'h0f);
    rdchk(PWR_OFS, 8'hff, 8'h10);
    rdchk(STAT_OFS, 8'hdf, 8'h96);
    {clock_source_switched, fifo_empty_flag, card_a_present, card_b_present} = 4'b0101;
    aux_interrupt_input = 1'b0;
    rdchk(STAT_OFS, 8'hdf, 8'h58);
    rdchk(TOR_LOW_OFS, 8'hff, 8'h00);
    cpt_host_i.rd(4'h3, d, e);
    chk1(e, 1'b0);
    // Supply, contacts, with direction toggling underneath
    for (int i = 0; i < 4; i++)
    begin
      dir_transmit = i[0];
      wr(PWR_OFS, pwr_w[i]);
      chk8(8'(card_supply_sel[0]), 8'(sup_x[i]));
      chk1(contact_four_pullup[0], pwr_w[i][4]);
      chk1(contact_eight_pullup[0], pwr_w[i][5]);
      rdchk(PWR_OFS, 8'hff, {4'h1, pwr_w[i][3:0]});
    end
    card_activated = 2'b01;
    {act_n, deact_n} = '0;
    wr(PWR_OFS, 8'h05);
    chk1(card_start[0], 1'b1);
    chk1(card_reset_pin[0], 1'b1);
    chk8(8'(act_n), 8'h01);
    emergency_deact = 2'b01;
    tick();
    emergency_deact = 2'b00;
    ticks(2);
    chk1(card_start[0], 1'b0);
    rdchk(PWR_OFS, 8'hff, 8'h14);
    wr(PWR_OFS, 8'h00);
    chk8(8'(deact_n), 8'h01);
    chk1(card_reset_pin[0], 1'b0);
    card_select = 2'h1;
    wr(PWR_OFS, 8'h0a);
    chk8(8'(card_supply_sel[1]), 8'(VCC_1V8));
    chk8(8'(card_supply_sel[0]), 8'(VCC_5V));
    rdchk(PWR_OFS, 8'hff, 8'h2a);
    card_select = 2'h0;
    // Soft reset keeps reloads, low nibble and start access
    wr(TOR_LOW_OFS, 8'h03);
    wr(TOR_MID_OFS, 8'h02);
    wr(TOR_HIGH_OFS, 8'h00);
    wr(PWR_OFS, 8'h0d);
    wr(CFG_OFS, 8'h05);
    rdchk(CFG_OFS, 8'hff, 8'h05);
    fifo_empty_flag = 1'b0;
    uart_soft_reset_n = 1'b0;
    ticks(2);
    chk8(8'({contact_eight_pullup[0], contact_four_pullup[0]}), 8'h03);
    rdchk(PWR_OFS, 8'h0f, 8'h0d);
    rdchk(CFG_OFS, 8'hff, 8'h00);
    wr(CFG_OFS, 8'h07);
    rdchk(CFG_OFS, 8'hff, 8'h00);
    wr(PWR_OFS, 8'h0c);
    chk1(card_start[0], 1'b0);
    rdchk(STAT_OFS, 8'h51, 8'h50);
    uart_soft_reset_n = 1'b1;
    tick();
    // Split counters stall without card clock
    wr(CFG_OFS, 8'h03);
    ev = '{0, 0, 0};
    ticks(100);
    chk8(8'(ev[0] + ev[1]), 8'h00);
    card_clock_active = 1'b1;
    ticks(40);
    chk8(8'(ev[0]), 8'h01);
    chk8(8'(ev[1]), 8'h01);
    chk8(8'(ev[2]), 8'h00);
    wr(CFG_OFS, 8'h06);
    ev = '{0, 0, 0};
    ticks(4000);
    chk8(8'(ev[2]), 8'h00);
    ticks(400);
    chk8(8'(ev[2]), 8'h01);
    chk8(8'(ev[0]), 8'h00);
    // Transfer flag and ready hold-off
    dir_transmit = 1'b0;
    ticks(2);
    dir_transmit = 1'b1;
    ticks(2);
    chk1(tx_empty_rx_full_flag, 1'b1);
    rlow = 0;
    wr(HOLDING_OFS, 8'h55);
    ticks(8);
    chk8(8'(rlow), 8'h03);
    chk1(tx_empty_rx_full_flag, 1'b0);
    send_char(1'b0);
    chk1(tx_empty_rx_full_flag, 1'b1);
    wr(HOLDING_OFS, 8'h00);
    send_char(1'b1);
    chk1(tx_empty_rx_full_flag, 1'b0);
    send_char(1'b0);
    dir_transmit = 1'b0;
    ticks(2);
    chk1(tx_empty_rx_full_flag, 1'b0);
    rx_fifo_full = 1'b1;
    ticks(2);
    chk1(tx_empty_rx_full_flag, 1'b1);
    rlow = 0;
    cpt_host_i.rd(HOLDING_OFS, d, e);
    ticks(8);
    chk8(8'(rlow), 8'h03);
    chk1(tx_empty_rx_full_flag, 1'b0);
    rx_fifo_full = 1'b0;
    rlow = 0;
    wr(CFG_OFS, 8'h00);
    ticks(10);
    chk1(rlow >= 1 && rlow <= 6, 1'b1);
    sync_mode = 1'b1;
    rlow = 0;
    wr(HOLDING_OFS, 8'h00);
    ticks(8);
    chk8(8'(rlow), 8'h00);
    sync_mode = 1'b0;
    // Guard flag for both protocols
    for (int i = 0; i < 2; i++)
    begin
      protocol_t1 = i[0];
      start_bit_seen = 1'b1;
      tick();
      start_bit_seen = 1'b0;
      ticks(2);
      chk1(block_guard_flag, 1'b0);
      ticks(i ? 150 : 104);
      chk1(block_guard_flag, 1'b0);
      ticks(i ? 48 : 32);
      chk1(block_guard_flag, 1'b1);
      rdchk(STAT_OFS, 8'h20, 8'h20);
    end
    stop_test();
  end
endmodule
`default_nettype wire
